// *** src/byte_fifo.v ***
`timescale 1ns/10ps
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clk_sys,
  input wire rst,
  input wire flush,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output reg [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready,
  output wire [AW:0] level
);
  // Full level held at the pointer width, so the compare drops no bits.
  localparam [AW:0] FULL_LEVEL = DEPTH;
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_q;
  reg [AW:0] rd_q;
  wire push;
  wire pop;
  assign level = wr_q - rd_q;
  assign in_ready = (level != FULL_LEVEL) && !flush;
  assign out_valid = (level != {(AW+1){1'b0}}) && !flush;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always @(posedge clk_sys) begin
    if (push)
      mem[wr_q[AW-1:0]] <= in_data;
  end
  always @* begin
    out_data = mem[rd_q[AW-1:0]];
  end
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end else if (flush) begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
    end
  end
endmodule // byte_fifo

// *** src/rs485_port.v ***
`timescale 1ns/10ps
`include "xcvr_defs.vh"
// Operation
// [R1] Four-wire mode keeps driver and receiver enabled at all times.
// [R2] Four-wire mode is the mode after reset.
// [R3] Echo mode drives the line only while terminal-ready is unasserted.
// [R4] Echo mode keeps the receiver enabled so own bytes come back.
// [R5] Software clears terminal-ready before sending and sets it after.
// [R6] No-echo mode drives like echo mode and mutes the receiver meanwhile.
// [R7] Auto mode enables the driver from transmit-ready for each byte.
// [R8] Auto mode mutes the receiver while the driver is on.
// [R9] Terminal-ready is active low for transceiver control.
// [R10] Separate transmit and receive FIFOs, which can be enabled or not.
// [R11] Receive interrupt once the receive FIFO reaches its threshold.
// [R12] Software writes at most the block size per transmit interrupt.
// [R13] Bit rate, data bits, parity and stop bits are programmable.
// [R14] Modes act only on ports with an RS-485 line interface.
// [R15] Mode is chosen by control bytes 0x00 to 0x03 in the scratch byte.
// [R16] The scratch byte sits at offset 7 and switches the mode at once.
// [R17] In auto mode the driver stays on through the last stop bit.
module rs485_port (
  input wire clk_sys,
  input wire rst,
  input wire is_rs485,
  input wire [2:0] wr_addr,
  input wire [7:0] wr_data,
  input wire wr_en,
  output reg [7:0] mode_q,
  input wire [15:0] baud_div,
  input wire [1:0] data_bits,
  input wire [1:0] parity_sel,
  input wire stop_two,
  input wire fifo_en,
  input wire [2:0] rx_thresh,
  input wire [2:0] tx_block,
  input wire dtr_n,
  input wire [7:0] tx_data,
  input wire tx_valid,
  output wire tx_ready,
  output wire [7:0] rx_data,
  output wire rx_valid,
  input wire rx_ready,
  output reg rx_irq_q,
  output reg tx_irq_q,
  output reg [2:0] tx_allow_q,
  output reg parity_err_q,
  output reg tx_holding_ready_ind,
  output reg line_txd_q,
  input wire line_rxd,
  output reg drv_en_q,
  output reg rcv_en_q
);
  // ***************************************************************
  // Mode selection
  // ***************************************************************
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_q <= `MODE_RESET; // [R2]
    end else if (wr_en && wr_addr == `SCRATCH_OFFSET) begin
      mode_q <= wr_data; // [R15] [R16]
    end
  end

  function parity_of;
    input [7:0] d;
    input [1:0] nbits;
    input odd;
    reg [7:0] m;
    begin
      m = 8'hff >> (3 - nbits);
      parity_of = (^(d & m)) ^ odd;
    end
  endfunction

  // Unused upper data bits are filled with marks and never shifted out, and the parity bit sits
  // right after the last data bit, whatever the character length.
  function [9:0] tx_frame;
    input [7:0] d;
    input [1:0] nbits;
    input [1:0] psel;
    reg [9:0] f;
    begin
      f = {1'b1, d | ~(8'hff >> (2'h3 - nbits)), 1'b0};
      if (psel != `PARITY_NONE)
        f[{2'b00, nbits} + 4'h6] = parity_of(d, nbits, psel == `PARITY_ODD);
      tx_frame = f;
    end
  endfunction

  // ***************************************************************
  // FIFOs
  // ***************************************************************
  wire [7:0] txf_data;
  wire txf_valid;
  reg txf_pop;
  wire [2:0] txf_level;
  reg [7:0] rxs_data;
  reg rxs_valid;
  wire rxf_in_ready;
  wire [2:0] rxf_level;
  byte_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) u_txf (
    .clk_sys(clk_sys), .rst(rst), .flush(!fifo_en),
    .in_data(tx_data), .in_valid(tx_valid), .in_ready(tx_ready),
    .out_data(txf_data), .out_valid(txf_valid), .out_ready(txf_pop),
    .level(txf_level)); // [R10]
  byte_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) u_rxf (
    .clk_sys(clk_sys), .rst(rst), .flush(!fifo_en),
    .in_data(rxs_data), .in_valid(rxs_valid), .in_ready(rxf_in_ready),
    .out_data(rx_data), .out_valid(rx_valid), .out_ready(rx_ready),
    .level(rxf_level)); // [R10]

  // ***************************************************************
  // Host indications
  // ***************************************************************
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_irq_q <= 1'b0;
      tx_irq_q <= 1'b0;
      tx_allow_q <= 3'h0;
    end else begin
      rx_irq_q <= fifo_en && (rx_thresh != 3'h0) &&
                  (rxf_level >= rx_thresh); // [R11]
      tx_irq_q <= fifo_en && txf_level == 3'h0;
      tx_allow_q <= (tx_block > 3'h4) ? 3'h4 : tx_block; // [R12]
    end
  end

  // ***************************************************************
  // Transmitter
  // ***************************************************************
  localparam TX_IDLE = 2'h0;
  localparam TX_SHIFT = 2'h1;
  localparam TX_STOP = 2'h2;
  reg [1:0] tx_st_q;
  reg [15:0] tx_cnt_q;
  reg [3:0] tx_bit_q;
  reg [9:0] tx_sh_q;
  reg [3:0] tx_len_q;
  reg tx_stop2_q;
  wire tx_tick;
  assign tx_tick = (tx_cnt_q == 16'h0000);

  always @* begin
    txf_pop = (tx_st_q == TX_IDLE) && txf_valid;
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_st_q <= TX_IDLE;
      tx_cnt_q <= 16'h0000;
      tx_bit_q <= 4'h0;
      tx_sh_q <= 10'h3ff;
      tx_len_q <= 4'h0;
      tx_stop2_q <= 1'b0;
      line_txd_q <= 1'b1;
      tx_holding_ready_ind <= 1'b0;
    end else begin
      tx_cnt_q <= tx_tick ? baud_div : tx_cnt_q - 16'h0001;
      case (tx_st_q)
        TX_IDLE: begin
          line_txd_q <= 1'b1;
          tx_holding_ready_ind <= 1'b0;
          if (txf_valid) begin
            tx_sh_q <= tx_frame(txf_data, data_bits, parity_sel); // [R13]
            tx_len_q <= 4'h5 + {2'h0, data_bits} +
                        {3'h0, parity_sel != `PARITY_NONE};
            tx_stop2_q <= stop_two;
            tx_bit_q <= 4'h0;
            tx_cnt_q <= baud_div;
            tx_holding_ready_ind <= 1'b1; // [R7]
            tx_st_q <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          line_txd_q <= tx_sh_q[0];
          if (tx_tick) begin
            if (tx_bit_q == tx_len_q) begin
              tx_bit_q <= 4'h0;
              tx_st_q <= TX_STOP;
              line_txd_q <= 1'b1;
            end else begin
              tx_bit_q <= tx_bit_q + 4'h1;
              tx_sh_q <= {1'b1, tx_sh_q[9:1]};
            end
          end
        end
        TX_STOP: begin
          line_txd_q <= 1'b1;
          // Hold the driver until the final stop bit has fully left.
          if (tx_tick) begin
            if (tx_stop2_q) begin
              tx_stop2_q <= 1'b0;
            end else begin
              tx_st_q <= TX_IDLE;
              tx_holding_ready_ind <= txf_valid; // [R17]
            end
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  // ***************************************************************
  // Receiver
  // ***************************************************************
  reg rxd_s1_q;
  reg rxd_s2_q;
  localparam RX_IDLE = 2'h0;
  localparam RX_DATA = 2'h1;
  localparam RX_STOP = 2'h2;
  reg [1:0] rx_st_q;
  reg [15:0] rx_cnt_q;
  reg [3:0] rx_bit_q;
  reg [8:0] rx_sh_q;
  wire rx_line;
  wire [3:0] rx_len;
  wire [8:0] rx_aligned;
  // A muted receiver reads idle, so no bytes are gathered during sends.
  assign rx_line = rcv_en_q ? rxd_s2_q : 1'b1;
  // Index of the last data or parity sample; the stop bit is checked apart.
  assign rx_len = 4'h4 + {2'h0, data_bits} +
                  {3'h0, parity_sel != `PARITY_NONE};
  assign rx_aligned = (rx_sh_q >> (4'h9 - rx_bit_q)) &
                      {1'b0, 8'hff >> (2'h3 - data_bits)};

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rxd_s1_q <= 1'b1;
      rxd_s2_q <= 1'b1;
      rx_st_q <= RX_IDLE;
      rx_cnt_q <= 16'h0000;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 9'h000;
      rxs_data <= 8'h00;
      rxs_valid <= 1'b0;
      parity_err_q <= 1'b0;
    end else begin
      rxd_s1_q <= line_rxd;
      rxd_s2_q <= rxd_s1_q;
      rxs_valid <= 1'b0;
      rx_cnt_q <= (rx_cnt_q == 16'h0000) ? 16'h0000 : rx_cnt_q - 16'h0001;
      case (rx_st_q)
        RX_IDLE: begin
          if (!rx_line) begin
            rx_cnt_q <= baud_div + {1'b0, baud_div[15:1]};
            rx_bit_q <= 4'h0;
            rx_sh_q <= 9'h000;
            rx_st_q <= RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_cnt_q == 16'h0000) begin
            rx_sh_q <= {rx_line, rx_sh_q[8:1]};
            rx_cnt_q <= baud_div;
            if (rx_bit_q == rx_len)
              rx_st_q <= RX_STOP;
            rx_bit_q <= rx_bit_q + 4'h1;
          end
        end
        RX_STOP: begin
          if (rx_cnt_q == 16'h0000) begin
            rx_st_q <= RX_IDLE;
            // Align the received bits to the low end of the byte.
            rxs_data <= rx_aligned[7:0];
            rxs_valid <= rx_line && rxf_in_ready;
            parity_err_q <= (parity_sel != `PARITY_NONE) &&
              (parity_of(rx_aligned[7:0], data_bits,
               parity_sel == `PARITY_ODD) != rx_sh_q[8]); // [R13]
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // ***************************************************************
  // Transceiver direction
  // ***************************************************************
  wire dtr_asserted;
  assign dtr_asserted = !dtr_n; // [R9]
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      drv_en_q <= 1'b1;
      rcv_en_q <= 1'b1;
    end else if (!is_rs485) begin
      drv_en_q <= 1'b1; // [R14]
      rcv_en_q <= 1'b1;
    end else begin
      case (mode_q)
        `MODE_ECHO: begin
          drv_en_q <= !dtr_asserted; // [R3] [R5]
          rcv_en_q <= 1'b1; // [R4]
        end
        `MODE_NO_ECHO: begin
          drv_en_q <= !dtr_asserted;
          rcv_en_q <= dtr_asserted; // [R6]
        end
        `MODE_AUTO: begin
          drv_en_q <= tx_holding_ready_ind; // [R7] [R17]
          rcv_en_q <= !tx_holding_ready_ind; // [R8]
        end
        default: begin
          drv_en_q <= 1'b1; // [R1]
          rcv_en_q <= 1'b1;
        end
      endcase
    end
  end
endmodule // rs485_port

// *** src/xcvr_defs.vh ***
`ifndef XCVR_DEFS_VH
`define XCVR_DEFS_VH
// Scratch register index, written through the byte port.
`define SCRATCH_OFFSET 3'h7
// Transceiver mode control bytes.
`define MODE_FOUR_WIRE 8'h00
`define MODE_ECHO 8'h01
`define MODE_NO_ECHO 8'h02
`define MODE_AUTO 8'h03
// Reset value of the mode byte.
`define MODE_RESET 8'h00
// Framing and FIFO reset values.
`define DIV_RESET 16'h006c
`define DATA_BITS_RESET 2'h3
`define PARITY_RESET 2'h0
`define STOP_RESET 1'h0
`define RX_THRESH_RESET 3'h1
`define TX_BLOCK_RESET 3'h4
// Parity selections.
`define PARITY_NONE 2'h0
`define PARITY_EVEN 2'h1
`define PARITY_ODD 2'h2
// FIFO geometry.
`define FIFO_DEPTH 4
`define FIFO_AW 2
`endif

// *** test/bus_node.sv ***
`timescale 1ns/10ps
// ****************************************
// Far node on the shared pair.
// ****************************************
module bus_node #(
  parameter int PER = 4
) (
  input wire clk_sys,
  input wire line_txd_q,
  input wire drv_en_q,
  output wire line_rxd
);
  logic node_drv = 1'b0;
  logic node_bit = 1'b1;
  logic [7:0] got_q = 8'h00;
  int got_n = 0;
  wire seen = drv_en_q ? line_txd_q : 1'b1;
  // Bias resistors hold an undriven pair at the idle mark level.
  assign line_rxd = node_drv ? node_bit : seen;
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    node_drv <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      node_bit <= f[i];
      repeat (PER) @(posedge clk_sys);
    end
    node_drv <= 1'b0;
  endtask
  // An early sample point tolerates an enable that lags the start bit.
  always begin
    @(negedge seen);
    repeat (PER / 2 - 1) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      repeat (PER) @(posedge clk_sys);
      got_q[i] = seen;
    end
    repeat (PER) @(posedge clk_sys);
    got_n++;
  end
endmodule // bus_node

// *** test/port_monitor.sv ***
`timescale 1ns/10ps
// ****************************************
// Transceiver enable, mode write and FIFO flush checks.
// ****************************************
module port_monitor (
  input wire clk_sys,
  input wire rst,
  input wire is_rs485,
  input wire [2:0] wr_addr,
  input wire [7:0] wr_data,
  input wire wr_en,
  input wire [7:0] mode_q,
  input wire fifo_en,
  input wire dtr_n,
  input wire tx_ready,
  input wire rx_valid,
  input wire tx_holding_ready_ind,
  input wire drv_en_q,
  input wire rcv_en_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_four;
    is_rs485 && mode_q == 8'h00 |=> drv_en_q && rcv_en_q;
  endproperty
  a_four: assert property (p_four) else $error("four");
  property p_echo;
    is_rs485 && mode_q == 8'h01 |=> drv_en_q == $past(dtr_n) && rcv_en_q;
  endproperty
  a_echo: assert property (p_echo) else $error("echo");
  property p_noecho;
    is_rs485 && mode_q == 8'h02 |=> drv_en_q == $past(dtr_n) && !rcv_en_q
      == drv_en_q;
  endproperty
  a_noecho: assert property (p_noecho) else $error("noecho");
  property p_auto;
    is_rs485 && mode_q == 8'h03 |=> drv_en_q ==
      $past(tx_holding_ready_ind) && rcv_en_q != drv_en_q;
  endproperty
  a_auto: assert property (p_auto) else $error("auto");
  property p_plain;
    !is_rs485 |=> drv_en_q && rcv_en_q;
  endproperty
  a_plain: assert property (p_plain) else $error("plain");
  property p_write;
    wr_en && wr_addr == 3'h7 |=> mode_q == $past(wr_data);
  endproperty
  a_write: assert property (p_write) else $error("write");
  property p_ignore;
    wr_en && wr_addr != 3'h7 |=> $stable(mode_q);
  endproperty
  a_ignore: assert property (p_ignore) else $error("ignore");
  property p_flush;
    !fifo_en ##1 !fifo_en |-> !tx_ready && !rx_valid;
  endproperty
  a_flush: assert property (p_flush) else $error("flush");
  c_auto: cover property (mode_q == 8'h03 && drv_en_q);
  c_echo: cover property (mode_q == 8'h01 && rx_valid);
  c_flush: cover property (!fifo_en ##1 fifo_en);
endmodule // port_monitor

// *** test/rs485_port_bench.sv ***
`timescale 1ns/10ps
`include "xcvr_defs.vh"
// ****************************************
// Direction control bench.
// ****************************************
module rs485_port_bench;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic is_rs485 = 1'b1;
  logic [2:0] wr_addr = 3'h0;
  logic [7:0] wr_data = 8'h00;
  logic wr_en = 1'b0;
  logic fifo_en = 1'b1;
  logic [2:0] rx_thresh = 3'h1;
  logic dtr_n = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic tx_valid = 1'b0;
  logic rx_ready = 1'b0;
  wire [7:0] mode_q, rx_data;
  wire tx_ready, rx_valid, rx_irq_q, tx_holding_ready_ind;
  wire line_txd_q, line_rxd, drv_en_q, rcv_en_q;
  wire tx_irq_q, parity_err_q;
  wire [2:0] tx_allow_q;
  int mismatches = 0;
  int num_checks = 0;
  int cyc = 0;
  rs485_port rs485_port_i (.clk_sys, .rst, .is_rs485, .wr_addr, .wr_data,
    .wr_en, .mode_q, .baud_div(16'h0003), .data_bits(2'h3),
    .parity_sel(`PARITY_NONE), .stop_two(1'h0), .fifo_en, .rx_thresh,
    .tx_block(3'h4), .dtr_n, .tx_data, .tx_valid, .tx_ready, .rx_data,
    .rx_valid, .rx_ready, .rx_irq_q, .tx_irq_q, .tx_allow_q,
    .parity_err_q, .tx_holding_ready_ind, .line_txd_q, .line_rxd,
    .drv_en_q, .rcv_en_q);
  bus_node #(.PER(4)) bus_node_i (.clk_sys, .line_txd_q, .drv_en_q,
    .line_rxd);
  always #2.5 clk_sys = ~clk_sys;
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      finish_test();
    end
  end
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    wr_addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic push(input logic [7:0] b);
    tx_data <= b;
    tx_valid <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 20 && !tx_ready; i++) @(posedge clk_sys);
    tx_valid <= 1'b0;
  endtask
  task automatic pop;
    rx_ready <= 1'b1;
    @(posedge clk_sys);
    rx_ready <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_idle;
    repeat (3) @(posedge clk_sys);
    for (int i = 0; i < 400 && tx_holding_ready_ind; i++) @(posedge clk_sys);
    repeat (8) @(posedge clk_sys);
    #1;
  endtask
  task automatic t_modes;
    logic [1:0] m;
    for (int i = 0; i < 8; i++) begin
      m = i[2:1];
      dtr_n <= i[0];
      wr(`SCRATCH_OFFSET, {6'h00, m});
      wr(3'h3, 8'h02);
      #1;
      chk("mode", {6'h00, m}, mode_q);
      chk("drv", m == 0 || (m != 3 && i[0]), drv_en_q);
      chk("rcv", m != 2 || !i[0], rcv_en_q);
    end
    is_rs485 <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("plain", 8'h01, drv_en_q && rcv_en_q);
    chk("allow", 8'h04, {5'h00, tx_allow_q});
    is_rs485 <= 1'b1;
    $display("test modes done");
  endtask
  task automatic t_auto;
    logic [7:0] k;
    int g;
    wr(`SCRATCH_OFFSET, `MODE_AUTO);
    g = bus_node_i.got_n;
    k = 8'h50;
    tx_data <= k;
    tx_valid <= 1'b1;
    repeat (12) begin
      @(posedge clk_sys);
      if (tx_ready) begin
        k = k + 8'h01;
        tx_data <= k;
      end
    end
    tx_valid <= 1'b0;
    #1;
    chk("taken", 8'h55, k);
    chk("drv", 8'h01, drv_en_q);
    chk("rcv", 8'h00, rcv_en_q);
    for (int i = 0; i < 400 && bus_node_i.got_n < g + 5; i++) begin
      @(posedge clk_sys);
    end
    chk("sent", 8'h54, bus_node_i.got_q);
    wait_idle();
    chk("idle", 8'h01, !drv_en_q && rcv_en_q);
    chk("txirq", 8'h01, tx_irq_q);
    $display("test auto done");
  endtask
  task automatic t_echo(input logic [7:0] m, input logic [7:0] e);
    wr(`SCRATCH_OFFSET, m);
    dtr_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    push(8'h3c);
    wait_idle();
    dtr_n <= 1'b0;
    chk("echo", e, rx_valid);
    chk("rxirq", e, rx_irq_q);
    if (e) chk("echodata", 8'h3c, rx_data);
    pop();
    $display("test echo %0d done", m);
  endtask
  task automatic t_fill;
    logic [7:0] k;
    wr(`SCRATCH_OFFSET, `MODE_ECHO);
    rx_thresh <= 3'h4;
    for (k = 8'ha0; k < 8'ha5; k++) begin
      bus_node_i.send(k);
      repeat (8) @(posedge clk_sys);
      #1;
      chk("rxirq", k > 8'ha2, rx_irq_q);
    end
    chk("parity", 8'h00, parity_err_q);
    for (k = 8'ha0; k < 8'ha4; k++) begin
      chk("rxdata", k, rx_data);
      pop();
    end
    chk("empty", 8'h00, rx_valid);
    fifo_en <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("flush", 8'h00, tx_ready);
    fifo_en <= 1'b1;
    $display("test fill done");
  endtask
  task automatic t_reset;
    wr(`SCRATCH_OFFSET, `MODE_AUTO);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk("mode", `MODE_RESET, mode_q);
    chk("both", 8'h01, drv_en_q && rcv_en_q);
    $display("test reset done");
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_modes();
    t_auto();
    t_echo(`MODE_ECHO, 8'h01);
    t_echo(`MODE_NO_ECHO, 8'h00);
    t_fill();
    t_reset();
    finish_test();
  end
endmodule // rs485_port_bench
bind rs485_port port_monitor port_monitor_i (.clk_sys, .rst, .is_rs485,
  .wr_addr, .wr_data, .wr_en, .mode_q, .fifo_en, .dtr_n, .tx_ready,
  .rx_valid, .tx_holding_ready_ind, .drv_en_q, .rcv_en_q);
